/* File: rtl/sgsel_top.sv */
// Parameter group priority selector with time-stamped events
//
// Overview of operation
// R1 - used_groups picks groups in use, one alone up to one..eight, default one
// R2 - A newly enabled group gets a default-load pulse
// R3 - Remote change input: none or group one..eight, none by default
// R4 - Remote change refused while a higher group request is held
// R5 - Each group request may be a pulse or a held level
// R6 - Group one ranks highest, group eight lowest
// R7 - A held group one request blocks every other request
// R8 - A held group n request blocks requests for groups above n
// R9 - A held group eight request blocks nothing
// R10 - Events carry a time stamp; on and off storage chosen per event
// R11 - On/off events for enable of two..eight, requests and active state
// R12 - On/off events for the remote change request
// R13 - On/off events for the local change request
// R14 - Request for an unused group fails and does not activate
// R15 - Request refused by forcing raises a failure event
// R16 - Request refused by higher priority raises a failure event
// R17 - Return to group one only when explicitly requested
// R18 - Group chosen by a pulse stays active until another is chosen
// R19 - While forcing, only the forced group is applied
// R20 - At most eight groups; group one active by default
// R21 - Arbitration every cycle; active group updates the next cycle
// R22 - Reset selects group one and clears latched state and events
// R23 - Active off for the old group in the same cycle as new on
module sgsel_top
  import sgsel_pkg::*;
#(
  parameter int unsigned TS_W = 32
) (
  input  wire logic                       ref_clk,        // System clock
  input  wire logic                       rst_b,          // Sync reset
  input  wire logic [sgsel_pkg::USED_W-1:0] used_groups,  // Groups in use-1
  input  wire logic [7:0]                 group_req,      // Bit0 = group one
  input  wire logic [sgsel_pkg::SEL_W-1:0] remote_change, // 0 none, 1..8
  input  wire logic [sgsel_pkg::SEL_W-1:0] local_change,  // 0 none, 1..8
  input  wire logic                       force_enable,   // Forcing on
  input  wire logic [sgsel_pkg::SEL_W-1:0] force_group,   // 0 none, 1..8
  input  sgsel_pkg::sgsel_ev_t            store_on_mask,  // Keep on events
  input  sgsel_pkg::sgsel_ev_t            store_off_mask, // Keep off events
  output logic [7:0]                      active_group,   // One-hot active
  output logic [7:0]                      load_defaults,  // Default load
  output sgsel_pkg::sgsel_ev_t            group_selector_events_on,  // On
  output sgsel_pkg::sgsel_ev_t            group_selector_events_off, // Off
  output logic                            event_valid,    // Any event
  output logic [TS_W-1:0]                 event_stamp     // Event time
);
  import sgsel_pkg::*;

  // Elaboration check on the stamp width
  if (TS_W < 8 || TS_W > 64) begin : g_ts_w_check
    $error("TS_W out of range");
  end

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] sel_dec(input logic [3:0] sel);
    logic [7:0] r;
    r = 8'h00;
    if (sel != SEL_NONE && sel <= 4'h8) begin
      r = 8'h01 << (sel - 4'h1);
    end
    return r;
  endfunction

  function automatic logic [7:0] pick_first(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = GROUPS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'h01 << i;
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]      act_reg;
  logic [7:0]      cfg_reg;
  logic [7:0]      req_reg;
  logic [3:0]      rem_sel_reg;
  logic [3:0]      loc_sel_reg;
  logic            force_reg;
  logic            fail_cfg_reg;
  logic            fail_frc_reg;
  logic            fail_pri_reg;
  logic [7:0]      load_reg;
  sgsel_ev_t       stat_prev_reg;
  sgsel_ev_t       ev_on_reg;
  sgsel_ev_t       ev_off_reg;
  logic            ev_valid_reg;
  logic [TS_W-1:0] ts_reg;
  logic [TS_W-1:0] stamp_reg;

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  logic [7:0] cfg_next;
  logic [7:0] blk;
  logic [7:0] cand;
  logic [7:0] cand_ok;
  logic [7:0] win;
  logic [7:0] force_tgt;
  logic [7:0] act_next;
  logic       rem_new;
  logic       loc_new;
  logic       fail_cfg_next;
  logic       fail_frc_next;
  logic       fail_pri_next;

  always_comb begin
    cfg_next = 8'((16'h0002 << used_groups) - 16'h0001);  // see R1
    blk[0] = 1'b0;
    for (int i = 1; i < GROUPS; i++) begin
      blk[i] = blk[i-1] | group_req[i-1];  // see R7 see R8 see R9
    end
    rem_new = (remote_change != SEL_NONE)
              && (remote_change != rem_sel_reg);  // see R3
    loc_new = (local_change != SEL_NONE)
              && (local_change != loc_sel_reg);
    // Rising request edges: pulse or start of a level
    cand = (group_req & ~req_reg)                  // see R5
           | (rem_new ? sel_dec(remote_change) : 8'h00)
           | (loc_new ? sel_dec(local_change) : 8'h00);
    cand_ok = cand & ~blk & cfg_next;              // see R4
    win = pick_first(cand_ok);                     // see R6
    force_tgt = sel_dec(force_group) & cfg_next;
    act_next = act_reg;                            // see R18 see R17
    fail_cfg_next = 1'b0;
    fail_frc_next = 1'b0;
    fail_pri_next = 1'b0;
    if (force_enable) begin
      if (force_tgt != 8'h00) begin
        act_next = force_tgt;                      // see R19
      end
      fail_frc_next = (cand != 8'h00);             // see R15
    end else begin
      if (win != 8'h00) begin
        act_next = win;                            // see R21
      end
      fail_cfg_next = (cand & ~cfg_next) != 8'h00; // see R14
      fail_pri_next = ((cand & cfg_next & blk) != 8'h00)
                      || ((cand_ok & ~win) != 8'h00);  // see R16
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      act_reg <= ACT_RST;                          // see R22 see R20
    end else begin
      act_reg <= act_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      req_reg     <= 8'h00;
      rem_sel_reg <= SEL_NONE;
      loc_sel_reg <= SEL_NONE;
      force_reg   <= 1'b0;
    end else begin
      req_reg     <= group_req;
      rem_sel_reg <= remote_change;
      loc_sel_reg <= local_change;
      force_reg   <= force_enable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fail_cfg_reg <= 1'b0;
      fail_frc_reg <= 1'b0;
      fail_pri_reg <= 1'b0;
    end else begin
      fail_cfg_reg <= fail_cfg_next;
      fail_frc_reg <= fail_frc_next;
      fail_pri_reg <= fail_pri_next;
    end
  end

  // ---------------------------------------------------------------
  // Group enable and default loading
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_reg  <= CFG_RST;
      load_reg <= 8'h00;
    end else begin
      cfg_reg  <= cfg_next;
      load_reg <= cfg_next & ~cfg_reg;             // see R2
    end
  end

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  sgsel_ev_t stat;
  sgsel_ev_t rise;
  sgsel_ev_t fall;

  always_comb begin
    stat = {act_reg, fail_pri_reg, fail_frc_reg, fail_cfg_reg,
            force_reg, (loc_sel_reg != SEL_NONE),
            (rem_sel_reg != SEL_NONE), req_reg, cfg_reg[7:1]};  // see R11
    rise = stat & ~stat_prev_reg;                  // see R12 see R13
    fall = ~stat & stat_prev_reg;                  // see R23
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ts_reg <= '0;
    end else begin
      ts_reg <= ts_reg + TS_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stat_prev_reg <= {ACT_RST, 14'h0000, CFG_RST[7:1]};
      ev_on_reg     <= '0;
      ev_off_reg    <= '0;
      ev_valid_reg  <= 1'b0;
      stamp_reg     <= '0;
    end else begin
      stat_prev_reg <= stat;
      ev_on_reg     <= rise & store_on_mask;       // see R10
      ev_off_reg    <= fall & store_off_mask;
      ev_valid_reg  <= ((rise & store_on_mask) != '0)
                       || ((fall & store_off_mask) != '0);
      if (((rise & store_on_mask) != '0)
          || ((fall & store_off_mask) != '0)) begin
        stamp_reg <= ts_reg;                       // see R10
      end
    end
  end

  assign active_group              = act_reg;
  assign load_defaults             = load_reg;
  assign group_selector_events_on  = ev_on_reg;
  assign group_selector_events_off = ev_off_reg;
  assign event_valid               = ev_valid_reg;
  assign event_stamp               = stamp_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_reset_one;
    $rose(rst_b) |-> act_reg == ACT_RST && ev_on_reg == '0;
  endproperty
  a_reset_one: assert property (p_reset_one)  // see R22
    else $error("active group not one after reset");

  property p_win_next;
    !force_enable && win != 8'h00 |=> act_reg == $past(win);
  endproperty
  a_win_next: assert property (p_win_next)  // see R21
    else $error("winning request not applied next cycle");

  property p_pick_rank;
    !force_enable && cand_ok[0] |=> act_reg == 8'h01;
  endproperty
  a_pick_rank: assert property (p_pick_rank)  // see R6
    else $error("group one request did not win");

  property p_hold;
    !force_enable && cand == 8'h00 |=> act_reg == $past(act_reg);
  endproperty
  a_hold: assert property (p_hold)  // see R18
    else $error("active group changed without a request");

  property p_one_blocks;
    !force_enable && group_req[0] && req_reg[0] |=> $stable(act_reg);
  endproperty
  a_one_blocks: assert property (p_one_blocks)  // see R7
    else $error("held group one did not block");

  property p_force;
    force_enable && force_tgt != 8'h00 |=> act_reg == $past(force_tgt);
  endproperty
  a_force: assert property (p_force)  // see R19
    else $error("forced group not applied");

  property p_unused;
    !force_enable && (cand & ~cfg_next) != 8'h00
      |=> fail_cfg_reg
          && (act_reg & ~$past(act_reg) & ~cfg_reg) == 8'h00;
  endproperty
  a_unused: assert property (p_unused)  // see R14
    else $error("unused group request not failed");

  property p_force_fail;
    force_enable && cand != 8'h00 |=> ##1 stat_prev_reg[EV_F_FRC];
  endproperty
  a_force_fail: assert property (p_force_fail)  // see R15
    else $error("forced refusal not flagged");

  property p_remote_block;
    !force_enable && rem_new
      && (sel_dec(remote_change) & blk & cfg_next) != 8'h00
      |=> fail_pri_reg;
  endproperty
  a_remote_block: assert property (p_remote_block)  // see R4
    else $error("blocked remote change not failed");

  property p_defaults;
    (cfg_next & ~cfg_reg) != 8'h00 |=> load_reg == $past(cfg_next & ~cfg_reg);
  endproperty
  a_defaults: assert property (p_defaults)  // see R2
    else $error("newly enabled group not loaded");

  sequence s_act_change;
    act_reg != $past(act_reg);
  endsequence

  property p_swap;
    s_act_change |-> rise[EV_NUM-1:EV_ACT_LSB] == act_reg
      && fall[EV_NUM-1:EV_ACT_LSB] == stat_prev_reg[EV_NUM-1:EV_ACT_LSB];
  endproperty
  a_swap: assert property (p_swap)  // see R23
    else $error("active on and off not in same cycle");

  property p_store;
    1'b1 |=> ev_on_reg == $past(rise & store_on_mask)
      && ev_off_reg == $past(fall & store_off_mask);
  endproperty
  a_store: assert property (p_store)  // see R10
    else $error("event storage selection wrong");

  property p_pri_fail;
    !force_enable && (cand & cfg_next & blk) != 8'h00 |=> fail_pri_reg;
  endproperty
  a_pri_fail: assert property (p_pri_fail)  // see R16
    else $error("blocked request not failed");

  property p_eight_free;
    !force_enable && group_req[7] && req_reg[7]
      && (cand[6:0] & cfg_next[6:0] & ~blk[6:0]) != 7'h00
      |=> act_reg[7] == 1'b0;
  endproperty
  a_eight_free: assert property (p_eight_free)  // see R9
    else $error("held group eight blocked a request");

endmodule

/* File: rtl/sgsel_pkg.sv */
// Constants for the parameter group priority selector
package sgsel_pkg;

  // ---------------------------------------------------------------
  // Group and selector widths
  // ---------------------------------------------------------------
  localparam int unsigned GROUPS  = 8;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned USED_W  = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACT_RST = 8'h01;
  localparam logic [7:0] CFG_RST = 8'h01;
  localparam logic [3:0] SEL_NONE = 4'h0;

  // ---------------------------------------------------------------
  // Event vector layout
  // ---------------------------------------------------------------
  localparam int unsigned EV_EN_LSB  = 0;
  localparam int unsigned EV_REQ_LSB = 7;
  localparam int unsigned EV_REM     = 15;
  localparam int unsigned EV_LOC     = 16;
  localparam int unsigned EV_FORCE   = 17;
  localparam int unsigned EV_F_CFG   = 18;
  localparam int unsigned EV_F_FRC   = 19;
  localparam int unsigned EV_F_PRI   = 20;
  localparam int unsigned EV_ACT_LSB = 21;
  localparam int unsigned EV_NUM     = 29;

  typedef logic [EV_NUM-1:0] sgsel_ev_t;

endpackage

/* File: bench/sgsel_far_end.sv */
// Far-end application logic driving the group request lines
module sgsel_far_end (
  input  wire logic [7:0] level_req,  // Held requests
  input  wire logic [7:0] pulse_req,  // One-cycle requests
  output logic      [7:0] group_req   // Request lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Request drive
  // ---------------------------------------------------------------
  // Group one comes back only when asked for explicitly
  assign group_req = level_req | pulse_req;
endmodule

/* File: bench/setting_group_priority_selector_test.sv */
// Self-checking bench for the group priority selector
module setting_group_priority_selector_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sgsel_pkg::*;
  logic       ref_clk      = 1'b0;
  logic       rst_b        = 1'b0;
  logic [2:0] used_groups  = 3'h0;
  logic [7:0] lvl          = 8'h00;
  logic [7:0] pls          = 8'h00;
  logic [3:0] rem          = 4'h0;
  logic [3:0] loc          = 4'h0;
  logic       force_enable = 1'b0;
  logic [3:0] force_group  = 4'h0;
  sgsel_ev_t  on_mask      = '1;
  sgsel_ev_t  off_mask     = '1;
  logic [7:0] group_req;
  logic [7:0] active_group;
  logic [7:0] load_defaults;
  sgsel_ev_t  ev_on;
  sgsel_ev_t  ev_off;
  logic       event_valid;
  logic [31:0] event_stamp;
  int         fail_count   = 0;
  int         comparisons  = 0;

  always #4 ref_clk = ~ref_clk;

  sgsel_far_end u_sgsel_far_end (
    .level_req (lvl),
    .pulse_req (pls),
    .group_req (group_req)
  );

  sgsel_top u_sgsel_top (
    .ref_clk                   (ref_clk),
    .rst_b                     (rst_b),
    .used_groups               (used_groups),
    .group_req                 (group_req),
    .remote_change             (rem),
    .local_change              (loc),
    .force_enable              (force_enable),
    .force_group               (force_group),
    .store_on_mask             (on_mask),
    .store_off_mask            (off_mask),
    .active_group              (active_group),
    .load_defaults             (load_defaults),
    .group_selector_events_on  (ev_on),
    .group_selector_events_off (ev_off),
    .event_valid               (event_valid),
    .event_stamp               (event_stamp)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic compare_vec(input string w, input logic [7:0] e,
                             input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  task automatic compare_bit(input string w, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", w, e, g);
    end
  endtask

  task automatic compare_stamp(input string w, input logic [31:0] e,
                               input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Request taken and active group updated at first edge, events settled after the second
  task automatic apply(input logic [7:0] l, input logic [7:0] p,
                       input logic [3:0] r, input logic [3:0] c);
    @(negedge ref_clk);
    lvl = l;
    pls = p;
    rem = r;
    loc = c;
    @(posedge ref_clk);
    @(negedge ref_clk);
    pls = 8'h00;
    step(1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    compare_vec("active", 8'h01, active_group);
    compare_vec("defaults", 8'h00, load_defaults);
    compare_bit("valid", 1'b0, event_valid);
  endtask

  task automatic t_enable;
    @(negedge ref_clk);
    used_groups = 3'h2;
    step(1);
    compare_vec("defaults", 8'h06, load_defaults);
    step(1);
    compare_vec("enabled", 8'h03, {1'b0, ev_on[6:0]});
    @(negedge ref_clk);
    used_groups = 3'h7;
    step(1);
    compare_vec("defaults", 8'hf8, load_defaults);
  endtask

  task automatic t_pulse;
    logic [31:0] s0;
    apply(8'h00, 8'h04, 4'h0, 4'h0);
    compare_vec("active", 8'h04, active_group);
    compare_bit("active on", 1'b1, ev_on[23]);
    compare_bit("old off", 1'b1, ev_off[21]);
    compare_bit("req on", 1'b1, ev_on[9]);
    compare_bit("valid", 1'b1, event_valid);
    s0 = event_stamp;
    step(1);
    compare_bit("req off", 1'b1, ev_off[9]);
    compare_stamp("stamp", s0 + 32'h1, event_stamp);
    step(3);
    compare_vec("active", 8'h04, active_group);
  endtask

  task automatic t_level;
    apply(8'h02, 8'h00, 4'h0, 4'h0);
    compare_vec("active", 8'h02, active_group);
    apply(8'h02, 8'h10, 4'h0, 4'h0);
    compare_vec("active", 8'h02, active_group);
    compare_bit("fail pri", 1'b1, ev_on[20]);
    apply(8'h02, 8'h01, 4'h0, 4'h0);
    compare_vec("active", 8'h01, active_group);
  endtask

  task automatic t_one_eight;
    @(negedge ref_clk);
    on_mask[28] = 1'b0;
    apply(8'h80, 8'h00, 4'h0, 4'h0);
    compare_vec("active", 8'h80, active_group);
    compare_bit("masked on", 1'b0, ev_on[28]);
    compare_bit("old off", 1'b1, ev_off[21]);
    @(negedge ref_clk);
    on_mask[28] = 1'b1;
    apply(8'h80, 8'h40, 4'h0, 4'h0);
    compare_vec("active", 8'h40, active_group);
    apply(8'h01, 8'h00, 4'h0, 4'h0);
    apply(8'h01, 8'h02, 4'h0, 4'h0);
    compare_vec("active", 8'h01, active_group);
  endtask

  task automatic t_remote;
    apply(8'h02, 8'h00, 4'h0, 4'h0);
    apply(8'h02, 8'h00, 4'h5, 4'h0);
    compare_vec("active", 8'h02, active_group);
    compare_bit("fail pri", 1'b1, ev_on[20]);
    apply(8'h00, 8'h00, 4'h0, 4'h0);
    apply(8'h00, 8'h00, 4'h5, 4'h0);
    compare_vec("active", 8'h10, active_group);
    compare_bit("remote on", 1'b1, ev_on[15]);
    apply(8'h00, 8'h00, 4'h0, 4'h3);
    compare_vec("active", 8'h04, active_group);
    compare_bit("local on", 1'b1, ev_on[16]);
    compare_bit("remote off", 1'b1, ev_off[15]);
  endtask

  task automatic t_unused_force;
    @(negedge ref_clk);
    used_groups = 3'h1;
    apply(8'h00, 8'h08, 4'h0, 4'h0);
    compare_vec("active", 8'h04, active_group);
    compare_bit("fail cfg", 1'b1, ev_on[18]);
    @(negedge ref_clk);
    force_group = 4'h2;
    force_enable = 1'b1;
    step(2);
    compare_vec("active", 8'h02, active_group);
    compare_bit("force on", 1'b1, ev_on[17]);
    apply(8'h00, 8'h01, 4'h0, 4'h0);
    compare_vec("active", 8'h02, active_group);
    compare_bit("fail force", 1'b1, ev_on[19]);
  endtask

  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset();
    t_enable();
    t_pulse();
    t_level();
    t_one_eight();
    t_remote();
    t_unused_force();
    close_out();
  end
endmodule
